// ---- adc_port_pkg.sv ----
// Purpose: Shared constants, types and coding helper for the result port.
// Assumes: One 16-bit result word per conversion.
// Notes:   Everything is referenced with a package scope, nothing is imported.
`default_nettype none
package adc_port_pkg;
  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int RESULT_WIDTH = 16;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam logic [4:0] COUNT_ONE = 5'h01;
  localparam logic [1:0] PHASE_RISE = 2'h1;
  localparam logic [1:0] PHASE_HIGH = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [7:0] QUARTER_BASE = 8'h02;
  localparam logic [7:0] QUARTER_ZERO = 8'h00;
  localparam logic [15:0] ALL_PINS = 16'hffff;
  localparam logic [15:0] UPPER_PINS = 16'hf000;
  localparam logic [15:0] NO_PINS = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       port_type_select;
    logic       clock_source_select;
    logic       bit_clock_invert;
    logic       frame_marker_polarity;
    logic       read_timing_or_chain_input;
    logic       output_coding_select;
    logic [1:0] internal_clock_divider;
  } pin_config_s;

  typedef enum logic {MASTER_IDLE, MASTER_SHIFT} master_state_e;

  // Straight binary when the select is high, top bit inverted when low.
  function automatic logic [15:0] coded(input logic [15:0] value, input logic straight);
    coded = straight ? value : {~value[15], value[14:0]};
  endfunction
endpackage
`default_nettype wire

// ---- bit_synchronizer.sv ----
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit is a slow level; no word coherence is promised.
// Notes:   The first stage feeds only the second stage.
`default_nettype none
module bit_synchronizer #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock) begin
    stage1   <= async_in;
    sync_out <= stage1;
  end
endmodule // bit_synchronizer
`default_nettype wire

// ---- adc_result_output_port.sv ----
// Purpose: Result output port, busy flag and control pins of the converter.
// Assumes: The converter core pulses conversion_start and conversion_done on clock.
// Notes:   Serial pin 8 carries serial_result_output in internal clock mode and
//          chained_result_output in external clock mode; the pad ring selects.
//
// Summary of operation
// - Bit clock is inverted by the invert pin, whichever side drives it.
// - External clock: chain input reappears on serial output sixteen periods later.
// - Internal clock: read-mode pin picks output during or after conversion.
// - Serial output shifts stored result, top bit first, in chosen coding.
// - Internal clock: each data bit stable across both bit clock edges.
// - External clock: data changes on rising edge, falling when inverted.
// - Bit clock pin direction follows the clock source select.
// - Internal clock: frame marker active during valid data, polarity by pin.
// - External clock: unfinished read at conversion end discards and pulses flag.
// - Top four data pins stay outputs in parallel and serial modes.
// - Busy rises at conversion start, falls once result is latched.
// - Output drivers enabled only while chip select and read are low.
// - Chip select gates the external bit clock.
// - Reset pin resets logic and aborts a running conversion.
// - Power-down finishes current conversion, then blocks new ones.
// - Parallel mode puts each result bit on its own data pin.
// - Port select low picks parallel, high picks serial.
// - Clock source low drives internal clock out, high takes external clock.
// - Coding select high gives straight binary, low inverts the top bit.
`default_nettype none
module adc_result_output_port (
  input  wire logic                      clock,
  input  wire logic                      srst,
  input  wire logic                      link_clock,
  input  wire adc_port_pkg::pin_config_s pin_config,
  input  wire logic                      chip_select_n,
  input  wire logic                      read_strobe_n,
  input  wire logic                      reset_request,
  input  wire logic                      power_down_request,
  input  wire logic                      conversion_start,
  input  wire logic                      conversion_done,
  input  wire logic [15:0]               conversion_data,
  output var  logic                      busy,
  output var  logic                      conversion_abort,
  output var  logic                      low_power,
  output var  logic [15:0]               data_out,
  output var  logic [15:0]               data_oe,
  output var  logic                      bit_clock_out,
  output var  logic                      bit_clock_oe,
  output var  logic                      frame_marker,
  output var  logic                      serial_result_output,
  output var  logic                      chained_result_output,
  output var  logic                      incomplete_read_flag
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  adc_port_pkg::pin_config_s cfg;
  logic                      cs_n_sync;
  logic                      rd_n_sync;
  logic                      reset_sync;
  logic                      pd_sync;
  logic                      link_active_sync;
  logic                      link_active;

  bit_synchronizer #(.WIDTH(13)) pin_sync (
    .clock    (clock),
    .async_in ({pin_config, chip_select_n, read_strobe_n, reset_request,
                power_down_request, link_active}),
    .sync_out ({cfg, cs_n_sync, rd_n_sync, reset_sync, pd_sync, link_active_sync})
  );

  logic enable;
  logic serial_mode;
  logic internal_mode;
  logic external_mode;
  logic start_event;
  logic done_event;

  assign enable        = !cs_n_sync && !rd_n_sync;
  assign serial_mode   = cfg.port_type_select;
  assign internal_mode = serial_mode && !cfg.clock_source_select;
  assign external_mode = serial_mode && cfg.clock_source_select;
  assign start_event   = !busy && conversion_start && !pd_sync && !reset_sync;
  assign done_event    = busy && conversion_done && !reset_sync;

  // ****************************************
  // Conversion control
  // ****************************************
  logic [15:0] result;
  logic        result_gen;

  always_ff @(posedge clock) begin
    if (srst || reset_sync) begin
      busy <= 1'b0;
    end else if (done_event) begin
      busy <= 1'b0;
    end else if (start_event) begin
      busy <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    conversion_abort <= !srst && reset_sync && busy;
    low_power        <= !srst && pd_sync && !busy;
  end

  always_ff @(posedge clock) begin
    if (srst || reset_sync) begin
      result     <= adc_port_pkg::RESULT_RESET;
      result_gen <= 1'b0;
    end else if (done_event) begin
      result     <= adc_port_pkg::coded(conversion_data, cfg.output_coding_select);
      // Only results taken in external clock mode are offered to the slave reader.
      if (external_mode) begin
        result_gen <= !result_gen;
      end
    end
  end

  // ****************************************
  // Parallel port
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      data_out <= adc_port_pkg::NO_PINS;
      data_oe  <= adc_port_pkg::NO_PINS;
    end else begin
      data_out <= serial_mode ? adc_port_pkg::NO_PINS : result;
      if (!enable) begin
        data_oe <= adc_port_pkg::NO_PINS;
      end else if (serial_mode) begin
        data_oe <= adc_port_pkg::UPPER_PINS;
      end else begin
        data_oe <= adc_port_pkg::ALL_PINS;
      end
    end
  end

  // ****************************************
  // Serial master with internal bit clock
  // ****************************************
  adc_port_pkg::master_state_e state;
  logic                        pending;
  logic [15:0]                 word;
  logic [7:0]                  quarter;
  logic [7:0]                  quarter_len;
  logic [1:0]                  phase;
  logic [4:0]                  bit_index;
  logic                        start_frame;
  logic                        quarter_end;
  logic                        shifting;

  assign quarter_len = adc_port_pkg::QUARTER_BASE << cfg.internal_clock_divider;
  assign quarter_end = (quarter == quarter_len - 8'h01);
  assign shifting    = (state == adc_port_pkg::MASTER_SHIFT);
  assign start_frame = internal_mode && enable && pending &&
                       (cfg.read_timing_or_chain_input ? busy : !busy);

  always_ff @(posedge clock) begin
    if (srst || reset_sync) begin
      pending <= 1'b0;
    end else if (done_event) begin
      pending <= 1'b1;
    end else if (!shifting && start_frame) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || reset_sync) begin
      state     <= adc_port_pkg::MASTER_IDLE;
      word      <= adc_port_pkg::RESULT_RESET;
      quarter   <= adc_port_pkg::QUARTER_ZERO;
      phase     <= 2'h0;
      bit_index <= 5'h00;
    end else begin
      case (state)
        adc_port_pkg::MASTER_IDLE: begin
          if (start_frame) begin
            state     <= adc_port_pkg::MASTER_SHIFT;
            word      <= result;
            quarter   <= adc_port_pkg::QUARTER_ZERO;
            phase     <= 2'h0;
            bit_index <= 5'h00;
          end
        end
        adc_port_pkg::MASTER_SHIFT: begin
          if (!enable) begin
            state <= adc_port_pkg::MASTER_IDLE;
          end else if (quarter_end) begin
            quarter <= adc_port_pkg::QUARTER_ZERO;
            phase   <= phase + 2'h1;
            if (phase == adc_port_pkg::PHASE_LAST) begin
              word      <= {word[14:0], 1'b0};
              bit_index <= bit_index + adc_port_pkg::COUNT_ONE;
              if (bit_index == adc_port_pkg::LAST_BIT) begin
                state <= adc_port_pkg::MASTER_IDLE;
              end
            end
          end else begin
            quarter <= quarter + 8'h01;
          end
        end
        default: begin
          state <= adc_port_pkg::MASTER_IDLE;
        end
      endcase
    end
  end

  // Data changes only at the start of phase 0, so both clock edges see it settled.
  always_ff @(posedge clock) begin
    if (srst) begin
      serial_result_output <= 1'b0;
      frame_marker         <= 1'b0;
      bit_clock_out        <= 1'b0;
      bit_clock_oe         <= 1'b0;
    end else begin
      serial_result_output <= shifting && word[15] && enable;
      frame_marker         <= shifting ^ cfg.frame_marker_polarity;
      bit_clock_out        <= (shifting && (phase == adc_port_pkg::PHASE_RISE ||
                               phase == adc_port_pkg::PHASE_HIGH)) ^ cfg.bit_clock_invert;
      bit_clock_oe         <= internal_mode && enable;
    end
  end

  // ****************************************
  // Incomplete read detection
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      incomplete_read_flag <= 1'b0;
    end else begin
      incomplete_read_flag <= done_event && external_mode && link_active_sync;
    end
  end

  // ****************************************
  // Serial slave on the external bit clock
  // ****************************************
  logic        link_edge_clock;
  logic        link_rst;
  logic        link_gen;
  logic        taken_gen;
  logic [15:0] link_shift;
  logic [4:0]  link_count;

  // Inverting the clock moves the update edge to the falling edge of the pin.
  assign link_edge_clock = link_clock ^ pin_config.bit_clock_invert;

  bit_synchronizer #(.WIDTH(2)) link_sync (
    .clock    (link_edge_clock),
    .async_in ({srst, result_gen}),
    .sync_out ({link_rst, link_gen})
  );

  always_ff @(posedge link_edge_clock) begin
    if (link_rst) begin
      link_active           <= 1'b0;
      link_count            <= 5'h00;
      taken_gen             <= 1'b0;
      link_shift            <= adc_port_pkg::RESULT_RESET;
      chained_result_output <= 1'b0;
    end else if (!chip_select_n && pin_config.port_type_select &&
                 pin_config.clock_source_select) begin
      if (!link_active && link_gen != taken_gen) begin
        link_active           <= 1'b1;
        link_count            <= adc_port_pkg::COUNT_ONE;
        taken_gen             <= link_gen;
        chained_result_output <= result[15];
        link_shift            <= {result[14:0], pin_config.read_timing_or_chain_input};
      end else if (link_active && link_gen != taken_gen) begin
        link_active <= 1'b0;
        link_count  <= 5'h00;
      end else begin
        chained_result_output <= link_shift[15];
        link_shift            <= {link_shift[14:0], pin_config.read_timing_or_chain_input};
        if (link_active) begin
          link_count <= link_count + adc_port_pkg::COUNT_ONE;
          if (link_count == adc_port_pkg::LAST_BIT) begin
            link_active <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence conversion_begins;
    start_event ##1 busy;
  endsequence

  sequence conversion_ends;
    done_event ##1 !busy;
  endsequence

  chk_busy_rise_start: assert property (@(posedge clock) disable iff (srst)
    start_event |=> busy)
    else $error("Busy did not rise at conversion start.");

  chk_busy_fall_latch: assert property (@(posedge clock) disable iff (srst)
    done_event |=> !busy && result == adc_port_pkg::coded($past(conversion_data),
                                                     $past(cfg.output_coding_select)))
    else $error("Busy fell without the coded result latched.");

  chk_reset_abort: assert property (@(posedge clock) disable iff (srst)
    reset_sync && busy |=> !busy ##1 !pending)
    else $error("Reset did not abort the conversion.");

  chk_pd_blocks_start: assert property (@(posedge clock) disable iff (srst)
    !busy && pd_sync && !reset_sync |=> !busy)
    else $error("A conversion started while powered down.");

  chk_oe_needs_select: assert property (@(posedge clock) disable iff (srst)
    !enable |=> data_oe == adc_port_pkg::NO_PINS)
    else $error("Data drivers on without chip select and read.");

  chk_upper_pins_out: assert property (@(posedge clock) disable iff (srst)
    enable && serial_mode |=> data_oe == adc_port_pkg::UPPER_PINS)
    else $error("Upper data pins not driven in serial mode.");

  chk_parallel_mapping: assert property (@(posedge clock) disable iff (srst)
    enable && !serial_mode ##1 enable |-> data_out == $past(result))
    else $error("Parallel pins do not mirror the result.");

  chk_marker_in_frame: assert property (@(posedge clock) disable iff (srst)
    shifting |=> frame_marker == !$past(cfg.frame_marker_polarity))
    else $error("Frame marker not asserted during serial output.");

  chk_flag_on_overrun: assert property (@(posedge clock) disable iff (srst)
    done_event && external_mode && link_active_sync |=> incomplete_read_flag ##1
    !incomplete_read_flag)
    else $error("Incomplete read flag not pulsed for one cycle.");

  chk_read_timing: assert property (@(posedge clock) disable iff (srst)
    internal_mode && pending && !shifting && (busy != cfg.read_timing_or_chain_input)
    |=> !shifting)
    else $error("Serial frame started in the wrong read mode.");

  chk_busy_holds: assert property (@(posedge clock) disable iff (srst)
    conversion_begins ##0 (!done_event && !reset_sync) |=> busy)
    else $error("Busy dropped before the conversion completed.");

  chk_link_word_len: assert property (@(posedge link_edge_clock) disable iff (link_rst)
    link_active |-> link_count != 5'h00 && link_count < adc_port_pkg::WORD_BITS)
    else $error("Slave read ran past sixteen bit periods.");
endmodule // adc_result_output_port
`default_nettype wire

// ---- host_link_model.sv ----
// Purpose: Host side of the serial slave link: bit clock bursts and capture.
// Assumes: The bench holds chip select; the model only makes clock edges.
// Notes:   The clock stands still between bursts and runs freely during reset.
`default_nettype none
module host_link_model (
  input  wire logic        srst,
  input  wire logic        inv,
  input  wire logic        req,
  input  wire logic        serial_in,
  input  wire logic [5:0]  nedge,
  output var  logic        link_clock,
  output var  logic        ack,
  output var  logic [31:0] word
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Burst generator
  // ****************************************
  logic raw = 1'b0;
  assign link_clock = raw ^ inv;
  initial begin
    ack = 1'b0;
    word = 32'h0000_0000;
  end
  always begin
    wait (req || srst);
    #1.3;
    if (srst) begin
      raw = 1'b1;
      #16;
      raw = 1'b0;
      #14.7;
    end else begin
      for (int i = 0; i < nedge; i++) begin
        raw = 1'b1;
        #16;
        word = {word[30:0], serial_in};
        raw = 1'b0;
        #16;
      end
      ack = 1'b1;
      wait (!req);
      ack = 1'b0;
    end
  end
endmodule // host_link_model
`default_nettype wire

// ---- test_adc_result_output_port.sv ----
// Purpose: Self-checking bench for the result output port.
// Assumes: Core pulses and pins are driven by the bench on the rising edge.
// Notes:   The serial slave host is a separate behavioural model.
`default_nettype none
module test_adc_result_output_port;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Signals and design
  // ****************************************
  logic                      clock = 1'b0;
  logic                      srst = 1'b1;
  adc_port_pkg::pin_config_s pin_config;
  logic                      chip_select_n, read_strobe_n, reset_request;
  logic                      power_down_request, conversion_start, conversion_done;
  logic [15:0]               conversion_data, data_out, data_oe;
  logic                      busy, conversion_abort, low_power, bit_clock_out;
  logic                      bit_clock_oe, frame_marker, serial_result_output;
  logic                      chained_result_output, incomplete_read_flag;
  logic                      link_clock, req, ack;
  logic [5:0]                nedge;
  logic [31:0]               word;
  int                        mismatches = 0;
  int                        compares = 0;
  int                        flags = 0;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (incomplete_read_flag === 1'b1) flags <= flags + 1;
  end
  adc_result_output_port DUT (
    .clock(clock), .srst(srst), .link_clock(link_clock), .pin_config(pin_config),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .reset_request(reset_request), .power_down_request(power_down_request),
    .conversion_start(conversion_start), .conversion_done(conversion_done),
    .conversion_data(conversion_data), .busy(busy), .conversion_abort(conversion_abort),
    .low_power(low_power), .data_out(data_out), .data_oe(data_oe),
    .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
    .frame_marker(frame_marker), .serial_result_output(serial_result_output),
    .chained_result_output(chained_result_output),
    .incomplete_read_flag(incomplete_read_flag));
  host_link_model partner (
    .srst(srst), .inv(pin_config.bit_clock_invert), .req(req),
    .serial_in(chained_result_output), .nedge(nedge), .link_clock(link_clock),
    .ack(ack), .word(word));
  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task results;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task give_up;
    mismatches++;
    results();
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic logic [15:0] code(input logic [15:0] v, input logic ob);
    code = ob ? v : {~v[15], v[14:0]};
  endfunction
  task cfg(input logic p, input logic s, input logic i, input logic y, input logic r,
           input logic o);
    @(posedge clock) pin_config <= '{p, s, i, y, r, o, 2'h0};
    tick(6);
  endtask
  task start_conv;
    @(posedge clock) conversion_start <= 1'b1;
    @(posedge clock) conversion_start <= 1'b0;
  endtask
  task finish_conv(input logic [15:0] v);
    @(posedge clock);
    conversion_data <= v;
    conversion_done <= 1'b1;
    @(posedge clock) conversion_done <= 1'b0;
    tick(2);
  endtask
  task convert(input logic [15:0] v);
    start_conv();
    tick(2);
    @(negedge clock) check(busy, 1'b1);
    finish_conv(v);
    @(negedge clock) check(busy, 1'b0);
  endtask
  task burst(input logic [5:0] n);
    int i;
    @(posedge clock);
    nedge <= n;
    req <= 1'b1;
    for (i = 0; i < 900 && ack !== 1'b1; i++) @(posedge clock);
    if (ack !== 1'b1) give_up();
    req <= 1'b0;
    @(posedge clock);
  endtask
  task par(input logic ob, input logic [15:0] v);
    @(posedge clock) chip_select_n <= 1'b1;
    @(posedge clock) read_strobe_n <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ob);
    convert(v);
    @(posedge clock) chip_select_n <= 1'b0;
    tick(6);
    check(data_oe, adc_port_pkg::NO_PINS);
    @(posedge clock) read_strobe_n <= 1'b0;
    tick(6);
    check(data_oe, adc_port_pkg::ALL_PINS);
    check(data_out, code(v, ob));
  endtask
  task master(input logic inv, input logic pol, input logic rt, input logic [15:0] v);
    int i;
    int n;
    logic b;
    logic p;
    logic [15:0] w;
    n = 0;
    p = 1'b0;
    w = 16'h0000;
    @(posedge clock) chip_select_n <= 1'b1;
    cfg(1'b1, 1'b0, inv, pol, rt, inv);
    convert(v);
    @(posedge clock) chip_select_n <= 1'b0;
    if (rt) start_conv();
    for (i = 0; i < 800 && (n < 16 || p); i++) begin
      @(negedge clock);
      b = bit_clock_out ^ inv;
      if (b && !p) begin
        w = {w[14:0], serial_result_output};
        n++;
        check(frame_marker, !pol);
        if (n == 1) check(busy, rt);
      end
      if (!b && p) check(serial_result_output, w[0]);
      p = b;
    end
    if (n < 16) give_up();
    check(w, code(v, inv));
    check(bit_clock_oe, 1'b1);
    if (rt) finish_conv(v);
  endtask
  task slave(input logic inv, input logic [15:0] v);
    @(posedge clock) chip_select_n <= 1'b1;
    cfg(1'b1, 1'b1, inv, 1'b0, 1'b1, inv);
    convert(v);
    check(bit_clock_oe, 1'b0);
    burst(6'h04);
    @(posedge clock) chip_select_n <= 1'b0;
    tick(4);
    burst(6'h20);
    check(word[31:16], code(v, inv));
    check(word[15:0], 16'hffff);
    check(data_oe, adc_port_pkg::UPPER_PINS);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int i;
    int f;
    logic seen;
    pin_config = '0;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    reset_request = 1'b0;
    power_down_request = 1'b0;
    conversion_start = 1'b0;
    conversion_done = 1'b0;
    conversion_data = 16'h0000;
    req = 1'b0;
    nedge = 6'h00;
    tick(20);
    @(posedge clock) srst <= 1'b0;
    tick(4);
    check(busy, 1'b0);
    check(frame_marker, 1'b0);
    par(1'b1, 16'ha5c3);
    par(1'b0, 16'h8001);
    master(1'b0, 1'b0, 1'b0, 16'h5a3c);
    master(1'b1, 1'b1, 1'b1, 16'hc00f);
    slave(1'b0, 16'h9617);
    slave(1'b1, 16'h3e81);
    convert(16'h1111);
    f = flags;
    burst(6'h08);
    convert(16'h2222);
    tick(12);
    check(16'(flags - f), 16'h0001);
    start_conv();
    tick(3);
    @(posedge clock) reset_request <= 1'b1;
    seen = 1'b0;
    for (i = 0; i < 12 && seen !== 1'b1; i++) @(negedge clock) seen = conversion_abort;
    check(seen, 1'b1);
    tick(3);
    check(busy, 1'b0);
    @(posedge clock) reset_request <= 1'b0;
    tick(4);
    start_conv();
    @(posedge clock) power_down_request <= 1'b1;
    tick(6);
    check(busy, 1'b1);
    finish_conv(16'h0f0f);
    check(busy, 1'b0);
    check(low_power, 1'b1);
    start_conv();
    tick(3);
    check(busy, 1'b0);
    results();
  end
endmodule // test_adc_result_output_port
`default_nettype wire
